/* File: sdl_pkg.sv */
package sdl_pkg;

  // ------------------------------------------------------------
  // Word format
  // ------------------------------------------------------------
  localparam int WORD_BITS = 16;
  localparam int CNT_BITS = 5;
  localparam logic [CNT_BITS-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_BITS-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_BITS-1:0] CNT_FULL = 5'h10;
  // Midcode in twos complement gives 0 V
  localparam logic [WORD_BITS-1:0] MIDCODE = 16'h0000;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int REF_PERIOD_NS = 50;
  localparam int T_UPDATE_NS = 1000;
  // Least time, rounded up to whole cycles
  localparam int UPDATE_CYCLES = (T_UPDATE_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int SETTLE_BITS = 8;
  localparam int FIFO_DEPTH = 4;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic zero;
    logic [WORD_BITS-1:0] code;
  } sdl_word_s;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SETTLE = 1'b1
  } sdl_drain_e;

endpackage : sdl_pkg

/* File: sdl_fifo.sv */
`timescale 1ns/1ps
module sdl_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Occupancy and handshakes
  assign count = wr_ptr_reg - rd_ptr_reg;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // Write pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
    end else if (push) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  // Read pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ptr_reg <= '0;
    end else if (pop) begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

endmodule : sdl_fifo

/* File: sdl_top.sv */
// Contract
// - Chip select high: bit clock and serial data are ignored.
// - Chip select is active low; words are accepted only while low.
// - Clear low at 16th clock: falling edge loads midcode.
// - Clear high at 16th clock: falling edge loads the shifted word.
// - Words are 16-bit twos complement, most significant bit first.
// - Output shows a new value no sooner than 1 us after update.
// - One bit shifts in on each rising clock after chip select falls.
// - After the update, further clocks are ignored until chip select falls.
// - Chip select rising before update discards the word, latch unchanged.
// - Clear never disturbs shifting; zero output holds until next update.
`timescale 1ns/1ps
module sdl_top
  import sdl_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // System clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Serial link from the host
  input wire logic BIT_CLK,
  input wire logic CS_N,
  input wire logic SERIAL_DATA_IN,
  input wire logic OUTPUT_ZERO_N,
  // Converter latch
  output logic [WORD_BITS-1:0] DAC_CODE,
  output logic DAC_UPDATED,
  output logic OUTPUT_ZEROED
);

  // ------------------------------------------------------------
  // Link domain (bit clock)
  // ------------------------------------------------------------

  logic link_rst;
  logic [WORD_BITS-1:0] shift_reg;
  logic [CNT_BITS-1:0] bit_cnt_reg;
  logic done_reg;
  sdl_word_s hold_reg;
  logic hold_tog_reg;
  logic capture;

  // Frame reset: chip select high or system reset
  // ignore when deselected
  assign link_rst = RST | CS_N;

  // Word capture on the 16th falling edge, once per frame
  assign capture = !CS_N && (bit_cnt_reg == CNT_FULL) && !done_reg;

  // Shift register, one bit per rising clock
  // shift on rise
  always_ff @(posedge BIT_CLK or posedge link_rst) begin
    if (link_rst) begin
      shift_reg <= MIDCODE;
    end else if (bit_cnt_reg != CNT_FULL) begin
      shift_reg <= {shift_reg[WORD_BITS-2:0], SERIAL_DATA_IN};
    end
  end

  // Bit counter, stops at sixteen
  // ignore extra clocks
  always_ff @(posedge BIT_CLK or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_reg <= CNT_ZERO;
    end else if (bit_cnt_reg != CNT_FULL) begin
      bit_cnt_reg <= bit_cnt_reg + CNT_ONE;
    end
  end

  // Update done flag, cleared by chip select high or system reset
  // one update per frame
  always_ff @(negedge BIT_CLK or posedge link_rst) begin
    if (link_rst) begin
      done_reg <= 1'b0;
    end else if (bit_cnt_reg == CNT_FULL) begin
      done_reg <= 1'b1;
    end
  end

  // Captured word on the 16th falling edge; kept past chip select rise
  // midcode on clear
  always_ff @(negedge BIT_CLK or posedge RST) begin
    if (RST) begin
      hold_reg <= '0;
    end else if (capture) begin
      hold_reg.zero <= !OUTPUT_ZERO_N;
      hold_reg.code <= OUTPUT_ZERO_N ? shift_reg : MIDCODE;
    end
  end

  // Event toggle toward the system domain
  // no toggle, no update
  always_ff @(negedge BIT_CLK or posedge RST) begin
    if (RST) begin
      hold_tog_reg <= 1'b0;
    end else if (capture) begin
      hold_tog_reg <= ~hold_tog_reg;
    end
  end

  // ------------------------------------------------------------
  // Crossing into the system domain
  // ------------------------------------------------------------

  logic tog_meta_reg;
  logic tog_sync_reg;
  logic tog_ack_reg;
  logic word_pending;
  logic push_ready;
  sdl_word_s push_word;

  // Two-stage toggle synchroniser
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tog_meta_reg <= 1'b0;
      tog_sync_reg <= 1'b0;
    end else begin
      tog_meta_reg <= hold_tog_reg;
      tog_sync_reg <= tog_meta_reg;
    end
  end

  // Hold word is stable for many system cycles after the toggle
  assign word_pending = (tog_sync_reg != tog_ack_reg);
  assign push_word = hold_reg;

  // Acknowledge only when the FIFO takes the word
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tog_ack_reg <= 1'b0;
    end else if (word_pending && push_ready) begin
      tog_ack_reg <= tog_sync_reg;
    end
  end

  // ------------------------------------------------------------
  // Word buffer
  // ------------------------------------------------------------

  logic pop_valid;
  logic pop_ready;
  sdl_word_s pop_word;

  sdl_fifo #(
    .WIDTH($bits(sdl_word_s)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(REF_CLK),
    .rst(RST),
    .in_valid(word_pending),
    .in_ready(push_ready),
    .in_data(push_word),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_word)
  );

  // ------------------------------------------------------------
  // Latch update with settle delay
  // ------------------------------------------------------------

  sdl_drain_e state_reg;
  sdl_drain_e state_next;
  logic [SETTLE_BITS-1:0] settle_reg;
  sdl_word_s next_word_reg;
  logic settle_end;
  logic load_now;

  assign pop_ready = (state_reg == ST_IDLE);
  assign settle_end = (settle_reg == SETTLE_BITS'(UPDATE_CYCLES - 1));
  // Last settle cycle: the latch loads now
  assign load_now = (state_reg == ST_SETTLE) && settle_end;

  // Drain state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (pop_valid) begin
          state_next = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (settle_end) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Settle counter
  // hold off 1 us
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      settle_reg <= '0;
    end else if (state_reg == ST_SETTLE) begin
      settle_reg <= settle_reg + 1'b1;
    end else begin
      settle_reg <= '0;
    end
  end

  // Word taken from the buffer
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      next_word_reg <= '0;
    end else if (pop_valid && pop_ready) begin
      next_word_reg <= pop_word;
    end
  end

  // Converter latch
  // midcode on reset
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      DAC_CODE <= MIDCODE;
    end else if (load_now) begin
      DAC_CODE <= next_word_reg.code;
    end
  end

  // Zero-output status, held until the next update
  // zero holds
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      OUTPUT_ZEROED <= 1'b1;
    end else if (load_now) begin
      OUTPUT_ZEROED <= next_word_reg.zero;
    end
  end

  // Update pulse
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      DAC_UPDATED <= 1'b0;
    end else begin
      DAC_UPDATED <= load_now;
    end
  end

endmodule : sdl_top

/* File: sdl_host_model.sv */
`timescale 1ns/1ps
module sdl_host_model (
  // Link to converter
  output logic bit_clk,
  output logic cs_n,
  output logic sdata
);
  // Idle link
  initial begin
    bit_clk = 1'b0;
    cs_n = 1'b1;
    sdata = 1'b0;
  end

  // One frame; sel low keeps chip select high
  task automatic frame(input logic [15:0] w, input int n, input int xtra, input logic sel);
    #7 cs_n = !sel;
    #40;
    for (int i = 0; i < n + xtra; i++) begin
      sdata = (i < 16) ? w[15-i] : ~sdata;
      #20 bit_clk = 1'b1;
      #40 bit_clk = 1'b0;
      #20;
    end
    #100 cs_n = 1'b1;
    sdata = ~sdata;
    #40;
  endtask : frame
endmodule : sdl_host_model

/* File: sdl_chk_assertions.sv */
`timescale 1ns/1ps
module sdl_chk
  import sdl_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clocks and reset
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic BIT_CLK,
  // Link
  input wire logic CS_N,
  input wire logic SERIAL_DATA_IN,
  input wire logic OUTPUT_ZERO_N,
  // Latch
  input wire logic [WORD_BITS-1:0] DAC_CODE,
  input wire logic DAC_UPDATED,
  input wire logic OUTPUT_ZEROED
);
  logic [4:0] fall_reg;
  logic tgl_reg;
  logic [2:0] sync_reg;
  logic [5:0] since_reg;
  logic seen;
  // Falls since chip select fell
  always_ff @(negedge BIT_CLK or posedge CS_N or posedge RST) begin
    if (CS_N || RST) fall_reg <= 5'h00;
    else fall_reg <= fall_reg + 5'h01;
  end
  // Toggle on the 16th fall
  always_ff @(negedge BIT_CLK or posedge RST) begin
    if (RST) tgl_reg <= 1'b0;
    else if (!CS_N && fall_reg == 5'h0f) tgl_reg <= ~tgl_reg;
  end
  // Bring toggle across
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) sync_reg <= 3'h0;
    else sync_reg <= {sync_reg[1:0], tgl_reg};
  end
  assign seen = sync_reg[2] ^ sync_reg[1];
  // Cycles since a word was seen
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) since_reg <= 6'h3f;
    else if (seen) since_reg <= 6'h00;
    else if (since_reg != 6'h3f) since_reg <= since_reg + 6'h01;
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  code_move_a: assert property ($changed(DAC_CODE) |-> DAC_UPDATED)
    else $error("code moved without pulse");
  zero_mid_a: assert property (OUTPUT_ZEROED |-> DAC_CODE == MIDCODE)
    else $error("zeroed but not midcode");
  zero_move_a: assert property ($changed(OUTPUT_ZEROED) |-> DAC_UPDATED)
    else $error("zeroed flag moved");
  upd_pulse_a: assert property (DAC_UPDATED |=> !DAC_UPDATED [*8])
    else $error("pulse too long");
  upd_late_a: assert property (DAC_UPDATED |-> since_reg >= 6'd17)
    else $error("update too early");
  upd_spur_a: assert property (DAC_UPDATED |-> since_reg <= 6'd31)
    else $error("update without word");
  upd_due_a: assert property (seen |-> ##[15:30] DAC_UPDATED)
    else $error("word not loaded");
  rst_mid_a: assert property ($fell(RST) |-> DAC_CODE == MIDCODE && OUTPUT_ZEROED)
    else $error("reset value wrong");
endmodule : sdl_chk

bind sdl_top sdl_chk #(.DEPTH(DEPTH)) chk (.REF_CLK(REF_CLK), .RST(RST), .BIT_CLK(BIT_CLK),
  .CS_N(CS_N), .SERIAL_DATA_IN(SERIAL_DATA_IN), .OUTPUT_ZERO_N(OUTPUT_ZERO_N),
  .DAC_CODE(DAC_CODE), .DAC_UPDATED(DAC_UPDATED), .OUTPUT_ZEROED(OUTPUT_ZEROED));

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  import sdl_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic zero_n = 1'b1;
  logic bit_clk, cs_n, ser_data, upd, zeroed;
  logic [WORD_BITS-1:0] code;
  int err_count = 0;
  int checks = 0;

  // Clock
  always #25 ref_clk = ~ref_clk;

  sdl_host_model host (.bit_clk(bit_clk), .cs_n(cs_n), .sdata(ser_data));
  sdl_top #(.DEPTH(4)) dut (.REF_CLK(ref_clk), .RST(rst), .BIT_CLK(bit_clk), .CS_N(cs_n),
    .SERIAL_DATA_IN(ser_data), .OUTPUT_ZERO_N(zero_n), .DAC_CODE(code), .DAC_UPDATED(upd),
    .OUTPUT_ZEROED(zeroed));

  task automatic bad(input string m);
    err_count++;
    $display("BAD %0t %s", $time, m);
  endtask : bad
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) bad("code");
  endtask : chk16
  task automatic chk1(input logic g, input logic e);
    checks++;
    if (g !== e) bad("flag");
  endtask : chk1
  // Wait for one update, then check latch
  task automatic wait_upd(input logic [15:0] c, input logic z);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (upd !== 1'b1 && n < 200);
    chk1(upd, 1'b1);
    chk16(code, c);
    chk1(zeroed, z);
  endtask : wait_upd
  // No update for 40 cycles
  task automatic quiet(input logic [15:0] c);
    logic hit;
    hit = 1'b0;
    repeat (40) begin
      @(posedge ref_clk);
      #1;
      if (upd !== 1'b0) hit = 1'b1;
    end
    chk1(hit, 1'b0);
    chk16(code, c);
  endtask : quiet

  // Plain words, sign and boundary codes
  task automatic t_words;
    logic [15:0] w [4] = '{16'h7fff, 16'h8000, 16'h4fff, 16'h0001};
    foreach (w[i]) begin
      host.frame(w[i], 16, 0, 1'b1);
      wait_upd(w[i], 1'b0);
    end
  endtask : t_words
  // Clear at 16th clock, then released mid-frame
  task automatic t_clear;
    @(posedge ref_clk);
    zero_n <= 1'b0;
    host.frame(16'h1234, 16, 0, 1'b1);
    wait_upd(MIDCODE, 1'b1);
    fork
      host.frame(16'hbfff, 16, 0, 1'b1);
      begin
        repeat (4) @(posedge ref_clk);
        zero_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
        chk1(zeroed, 1'b1);
        chk16(code, MIDCODE);
      end
    join
    wait_upd(16'hbfff, 1'b0);
  endtask : t_clear
  // Short frame, unselected clocks, extra clocks
  task automatic t_reject;
    host.frame(16'h5a5a, 10, 0, 1'b1);
    quiet(16'hbfff);
    host.frame(16'h5a5a, 16, 0, 1'b0);
    quiet(16'hbfff);
    fork
      host.frame(16'h2468, 16, 17, 1'b1);
      wait_upd(16'h2468, 1'b0);
    join
    quiet(16'h2468);
  endtask : t_reject
  // Frames back to back
  task automatic t_burst;
    logic [15:0] w [3] = '{16'h0f0f, 16'hf0f0, 16'h3c3c};
    fork
      foreach (w[i]) host.frame(w[i], 16, 0, 1'b1);
      foreach (w[i]) wait_upd(w[i], 1'b0);
    join
  endtask : t_burst

  task automatic summarize;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk16(code, MIDCODE);
    chk1(zeroed, 1'b1);
    #100000;
    t_words();
    t_clear();
    t_reject();
    t_burst();
    summarize();
  end
  // Watchdog
  initial begin
    #1000000;
    bad("timeout");
    summarize();
  end
endmodule : tb
